//--- uart_status_shadow_host.sv
// Host processor model that issues register bus transfers.
`timescale 1ns/1ps
`default_nettype none
module uart_status_shadow_host (
  input wire logic i_clk, // Bus clock.
  input wire logic i_pready, // Transfer complete.
  input wire logic [31:0] i_prdata, // Read data.
  output var uart_status_shadow_pkg::bus_req_s o_bus // Request.
);
  // The bus is idle until the first transfer.
  initial o_bus = '0;
  // One setup cycle, then access held until ready is sampled high or eight clocks pass.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    @(posedge i_clk);
    #1;
    o_bus = '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
    @(posedge i_clk);
    #1;
    o_bus.enable = 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (i_pready !== 1'b1 && k < 8);
    // Data is taken at the ready edge, the request is released after it.
    q = (i_pready === 1'b1) ? i_prdata : 32'hDEAD_BEEF;
    #1;
    o_bus = '0;
  endtask
endmodule
`default_nettype wire

//--- uart_status_shadow_map.svh
// Register offsets, field positions and reset values of the status and mirror bank.
`ifndef UART_STATUS_SHADOW_MAP_SVH
`define UART_STATUS_SHADOW_MAP_SVH
`define OFS_LINE_STATUS_FLAGS 8'h7C
`define OFS_TX_QUEUE_LEVEL 8'h80
`define OFS_RX_QUEUE_LEVEL 8'h84
`define OFS_SOFT_RESET_CTRL 8'h88
`define OFS_RTS_MIRROR 8'h8C
`define OFS_BREAK_MIRROR 8'h90
`define OFS_DMA_MODE_MIRROR 8'h94
`define OFS_QUEUE_CONTROL 8'h08
`define OFS_LINE_CONTROL 8'h0C
`define OFS_MODEM_CONTROL 8'h10
`define BIT_RX_FULL 4
`define BIT_RX_NOT_EMPTY 3
`define BIT_TX_EMPTY 2
`define BIT_TX_NOT_FULL 1
`define BIT_BUSY 0
`define BIT_UART_RESET 0
`define BIT_RX_QUEUE_RESET 1
`define BIT_TX_QUEUE_RESET 2
`define BIT_DMA_MODE 3
`define BIT_BREAK 6
`define BIT_RTS 1
`define QUEUE_DEPTH 5'h1F
`define RST_STATUS 5'h06
`define RST_LEVEL 5'h00
`define RST_RESET_SYNC_STAGES 2
`endif

//--- uart_status_shadow_pkg.sv
// Types shared by the status and mirror register bank.
`default_nettype none
package uart_status_shadow_pkg;
  // Register bus request from the host processor.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
  // Queue activity reported by the serial engine each cycle.
  typedef struct packed {
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic busy;
  } queue_evt_s;
  // Phase of the register bus access.
  typedef enum logic [1:0] {BUS_IDLE, BUS_SETUP, BUS_ACCESS} bus_phase_e;
endpackage
`default_nettype wire

//--- uart_status_shadow_regs.sv
// Status, queue level, soft reset and mirror control registers of a serial controller.
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_shadow_map.svh"
module uart_status_shadow_regs (
  input wire logic i_clk, // Bus clock.
  input wire logic i_rstn, // Asynchronous active low reset.
  input wire logic i_sclk, // Serial clock.
  input wire uart_status_shadow_pkg::bus_req_s i_bus, // Register bus request.
  input wire uart_status_shadow_pkg::queue_evt_s i_evt, // Queue activity.
  output logic [31:0] o_prdata, // Read data.
  output logic o_pready, // Transfer complete.
  output logic o_pslverr, // Error answer.
  output logic o_rstn_bus, // Controller reset for the bus domain.
  output logic o_rstn_serial, // Controller reset for the serial domain.
  output logic o_rts, // Request to send control.
  output logic o_break, // Break control.
  output logic o_dma_mode, // DMA mode control.
  output logic o_tx_clear, // Transmit queue was emptied this cycle.
  output logic o_rx_clear // Receive queue was emptied this cycle.
);
  // Write and read strobes during the access phase.
  logic wr_en;
  logic rd_en;
  // Queue counters and flag bits.
  logic [4:0] tx_level_r;
  logic [4:0] rx_level_r;
  logic [4:0] status_r;
  logic [4:0] tx_level_nxt;
  logic [4:0] rx_level_nxt;
  // Queue reset requests from either register.
  logic tx_reset_req;
  logic rx_reset_req;
  // Soft reset request and its synchronisers.
  logic soft_rst_r;
  logic [1:0] bus_sync_r;
  logic [1:0] ser_sync_r;
  logic rts_r;
  logic brk_r;
  logic dma_r;
  logic [31:0] rdata_nxt;

  // Strobes act once per transfer, in the first access cycle.
  // The completing cycle, with ready high, must not apply the same write a second time.
  assign wr_en = i_bus.sel & i_bus.enable & i_bus.write & ~o_pready;
  assign rd_en = i_bus.sel & i_bus.enable & ~i_bus.write & ~o_pready;

  // Queue reset may come from the soft reset control register or the queue control register.
  // transmit queue reset.
  assign tx_reset_req = wr_en & i_bus.wdata[`BIT_TX_QUEUE_RESET] &
      (i_bus.addr == `OFS_SOFT_RESET_CTRL || i_bus.addr == `OFS_QUEUE_CONTROL);
  assign rx_reset_req = wr_en & i_bus.wdata[`BIT_RX_QUEUE_RESET] &
      (i_bus.addr == `OFS_SOFT_RESET_CTRL || i_bus.addr == `OFS_QUEUE_CONTROL);

  // Next queue levels: reset wins over any push or pop in the same cycle.
  always_comb begin
    tx_level_nxt = tx_level_r;
    rx_level_nxt = rx_level_r;
    if (tx_reset_req) begin
      tx_level_nxt = `RST_LEVEL;
    end else if (i_evt.tx_push && !i_evt.tx_pop && tx_level_r != `QUEUE_DEPTH) begin
      tx_level_nxt = tx_level_r + 5'h01;
    end else if (i_evt.tx_pop && !i_evt.tx_push && tx_level_r != 5'h00) begin
      tx_level_nxt = tx_level_r - 5'h01;
    end
    if (rx_reset_req) begin
      rx_level_nxt = `RST_LEVEL;
    end else if (i_evt.rx_push && !i_evt.rx_pop && rx_level_r != `QUEUE_DEPTH) begin
      rx_level_nxt = rx_level_r + 5'h01;
    end else if (i_evt.rx_pop && !i_evt.rx_push && rx_level_r != 5'h00) begin
      rx_level_nxt = rx_level_r - 5'h01;
    end
  end

  // Queue level counters.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_level_r <= `RST_LEVEL;
      rx_level_r <= `RST_LEVEL;
    end else begin
      tx_level_r <= tx_level_nxt;
      rx_level_r <= rx_level_nxt;
    end
  end

  // Queue flags follow the next levels so they change with the counters; busy is registered from the event input.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_r <= `RST_STATUS;
    end else begin
      status_r[`BIT_RX_FULL] <= (rx_level_nxt == `QUEUE_DEPTH);
      status_r[`BIT_RX_NOT_EMPTY] <= (rx_level_nxt != 5'h00);
      status_r[`BIT_TX_EMPTY] <= (tx_level_nxt == 5'h00);
      status_r[`BIT_TX_NOT_FULL] <= (tx_level_nxt != `QUEUE_DEPTH);
      status_r[`BIT_BUSY] <= i_evt.busy;
    end
  end

  // Soft reset request, a one-cycle pulse that starts the reset.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_en && i_bus.addr == `OFS_SOFT_RESET_CTRL &&
          i_bus.wdata[`BIT_UART_RESET];
    end
  end

  // Bus domain reset: asserted at once by power reset and on the next bus clock by the soft reset pulse, released after three bus clocks.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_sync_r <= 2'b00;
      o_rstn_bus <= 1'b0;
    end else if (soft_rst_r) begin
      bus_sync_r <= 2'b00;
      o_rstn_bus <= 1'b0;
    end else begin
      bus_sync_r <= {bus_sync_r[0], 1'b1};
      o_rstn_bus <= bus_sync_r[1];
    end
  end

  // Serial domain reset: asserted asynchronously, released on the serial clock.
  always_ff @(posedge i_sclk or negedge i_rstn or posedge soft_rst_r) begin
    if (!i_rstn) begin
      ser_sync_r <= 2'b00;
      o_rstn_serial <= 1'b0;
    end else if (soft_rst_r) begin
      ser_sync_r <= 2'b00;
      o_rstn_serial <= 1'b0;
    end else begin
      ser_sync_r <= {ser_sync_r[0], 1'b1};
      o_rstn_serial <= ser_sync_r[1];
    end
  end

  // Mirror bits share storage with the full control registers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rts_r <= 1'b0;
      brk_r <= 1'b0;
      dma_r <= 1'b0;
    end else if (wr_en) begin
      if (i_bus.addr == `OFS_RTS_MIRROR) begin
        rts_r <= i_bus.wdata[0];
      end else if (i_bus.addr == `OFS_MODEM_CONTROL) begin
        rts_r <= i_bus.wdata[`BIT_RTS];
      end
      if (i_bus.addr == `OFS_BREAK_MIRROR) begin
        brk_r <= i_bus.wdata[0];
      end else if (i_bus.addr == `OFS_LINE_CONTROL) begin
        brk_r <= i_bus.wdata[`BIT_BREAK];
      end
      if (i_bus.addr == `OFS_DMA_MODE_MIRROR) begin
        dma_r <= i_bus.wdata[0];
      end else if (i_bus.addr == `OFS_QUEUE_CONTROL) begin
        dma_r <= i_bus.wdata[`BIT_DMA_MODE];
      end
    end
  end

  // Registered copies of the control bits and queue clear pulses.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rts <= 1'b0;
      o_break <= 1'b0;
      o_dma_mode <= 1'b0;
      o_tx_clear <= 1'b0;
      o_rx_clear <= 1'b0;
    end else begin
      o_rts <= rts_r;
      o_break <= brk_r;
      o_dma_mode <= dma_r;
      o_tx_clear <= tx_reset_req;
      o_rx_clear <= rx_reset_req;
    end
  end

  // Read data mux; write-only and unmapped addresses read zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (i_bus.addr)
      `OFS_LINE_STATUS_FLAGS: rdata_nxt[4:0] = status_r;
      `OFS_TX_QUEUE_LEVEL: rdata_nxt[4:0] = tx_level_r;
      `OFS_RX_QUEUE_LEVEL: rdata_nxt[4:0] = rx_level_r;
      `OFS_RTS_MIRROR: rdata_nxt[0] = rts_r;
      `OFS_BREAK_MIRROR: rdata_nxt[0] = brk_r;
      `OFS_DMA_MODE_MIRROR: rdata_nxt[0] = dma_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Bus answer registered: ready one cycle after the access phase begins.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_bus.sel & i_bus.enable & ~o_pready;
      o_pslverr <= 1'b0;
      if (rd_en) begin
        o_prdata <= rdata_nxt;
      end
    end
  end

  a_rx_full_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_r[`BIT_RX_FULL] == (rx_level_r == `QUEUE_DEPTH)) else $error("rx full wrong");
  a_rx_nonempty: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_r[`BIT_RX_NOT_EMPTY] == (rx_level_r != 5'h00)) else $error("rx nonempty wrong");
  a_tx_empty_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_r[`BIT_TX_EMPTY] == (tx_level_r == 5'h00)) else $error("tx empty wrong");
  a_tx_space_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_r[`BIT_TX_NOT_FULL] == (tx_level_r != `QUEUE_DEPTH)) else $error("tx space wrong");
  a_busy_follow: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_r[`BIT_BUSY] == $past(i_evt.busy)) else $error("busy wrong");
  a_tx_reset_empty: assert property (@(posedge i_clk) disable iff (!i_rstn)
    tx_reset_req |=> tx_level_r == 5'h00 && status_r[`BIT_TX_EMPTY]) else $error("tx reset");
  a_rx_reset_empty: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rx_reset_req |=> rx_level_r == 5'h00 && !status_r[`BIT_RX_NOT_EMPTY]) else $error("rx reset");
  sequence s_bus_rst_held;
    !o_rstn_bus ##1 !o_rstn_bus;
  endsequence
  a_soft_reset_bus: assert property (@(posedge i_clk) disable iff (!i_rstn)
    soft_rst_r |=> s_bus_rst_held) else $error("soft reset");
  a_dma_mirror_wr: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en && i_bus.addr == `OFS_DMA_MODE_MIRROR |=> dma_r == $past(i_bus.wdata[0]))
    else $error("dma mirror");
endmodule
`default_nettype wire

//--- uart_status_shadow_regs_test.sv
// Self-checking bench of the status and mirror register bank.
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_shadow_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module uart_status_shadow_regs_test;
  logic i_clk = 0, i_sclk = 0, i_rstn = 0, pslverr, tx_clr, rx_clr;
  uart_status_shadow_pkg::bus_req_s bus;
  uart_status_shadow_pkg::queue_evt_s evt = '0;
  logic [31:0] prdata, q;
  logic pready, rstn_bus, rstn_ser, rts, brk, dma;
  int err_total = 0, n_tests = 0, cyc = 0;
  // Cycles with the bus reset low, clear pulses, error answers, and a snapshot.
  int rst_low = 0, n_txclr = 0, n_rxclr = 0, n_slverr = 0, base = 0;
  // Read-back table after reset; the last row is an unmapped address.
  logic [7:0] ra[8] = '{8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'hF0};
  logic [31:0] rv[8] = '{32'h06, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  uart_status_shadow_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk),
    .i_bus(bus), .i_evt(evt), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_rstn_bus(rstn_bus), .o_rstn_serial(rstn_ser), .o_rts(rts), .o_break(brk),
    .o_dma_mode(dma), .o_tx_clear(tx_clr), .o_rx_clear(rx_clr));
  uart_status_shadow_host host (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata),
    .o_bus(bus));
  // Bus and serial clocks, the serial one offset in phase.
  initial forever #4 i_clk = ~i_clk;
  initial begin
    #1.5;
    forever #5 i_sclk = ~i_sclk;
  end
  // Cuts a hang short and counts reset cycles, clear pulses and error answers.
  always @(posedge i_clk) begin
    cyc++;
    if (i_rstn) begin
      if (rstn_bus === 1'b0) rst_low++;
      if (tx_clr === 1'b1) n_txclr++;
      if (rx_clr === 1'b1) n_rxclr++;
      if (pslverr !== 1'b0) n_slverr++;
    end
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reads one register and compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
    // A write that never completes counts as a mismatch.
    if (q === 32'hDEAD_BEEF) err_total++;
  endtask
  // Queue events, one entry per cycle.
  task automatic evts(input int n, input uart_status_shadow_pkg::queue_evt_s e);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      evt = e;
    end
    @(posedge i_clk);
    #1;
    evt = '{default: 1'b0, busy: e.busy};
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_rstn = 1;
    // Reset values of every register from 0x7C to 0x94 and of an unmapped address.
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    `CHK(rst_low, `RST_RESET_SYNC_STAGES + 1)
    // Both queues overfilled, serial engine busy.
    evts(32, '{tx_push: 1, rx_push: 1, busy: 1, default: 0});
    rd(8'h7C, 32'h19);
    rd(8'h80, 32'h1F);
    rd(8'h84, 32'h1F);
    evts(1, '{rx_pop: 1, busy: 1, default: 0});
    rd(8'h7C, 32'h09);
    rd(8'h84, 32'h1E);
    // Queue resets through the soft reset bits.
    wr(8'h88, 32'h4);
    `CHK(n_txclr, 1)
    rd(8'h80, 32'h0);
    rd(8'h7C, 32'h0F);
    wr(8'h88, 32'h2);
    `CHK(n_rxclr, 1)
    rd(8'h84, 32'h0);
    rd(8'h7C, 32'h07);
    evts(1, '0);
    rd(8'h7C, 32'h06);
    // Queue reset through the full control register.
    evts(3, '{tx_push: 1, default: 0});
    wr(8'h08, 32'h4);
    `CHK(n_txclr, 2)
    rd(8'h80, 32'h0);
    wr(8'h80, 32'h5);
    rd(8'h80, 32'h0);
    // Mirrors share storage with the full control registers.
    wr(8'h8C, 32'h1);
    rd(8'h8C, 32'h1);
    `CHK(rts, 1'b1)
    wr(8'h10, 32'h0);
    rd(8'h8C, 32'h0);
    wr(8'h90, 32'h1);
    rd(8'h90, 32'h1);
    `CHK(brk, 1'b1)
    wr(8'h0C, 32'h0);
    rd(8'h90, 32'h0);
    wr(8'h08, 32'h8);
    rd(8'h94, 32'h1);
    `CHK(dma, 1'b1)
    // Whole controller reset drops and releases both domains.
    base = rst_low;
    wr(8'h88, 32'h1);
    repeat (8) @(posedge i_clk);
    `CHK(rst_low - base, `RST_RESET_SYNC_STAGES + 1)
    `CHK(rstn_bus, 1'b1)
    `CHK(rstn_ser, 1'b1)
    `CHK(n_slverr, 0)
    // Power reset in mid-run returns levels, flags and mirrors to their reset values.
    evts(2, '{tx_push: 1, default: 0});
    i_rstn = 0;
    repeat (2) @(posedge i_clk);
    #1;
    i_rstn = 1;
    rd(8'h7C, 32'h06);
    rd(8'h80, 32'h0);
    rd(8'h94, 32'h0);
    `CHK(dma, 1'b0)
    complete_run();
  end
endmodule
`default_nettype wire
